// ===== tpg_defs.vh
// constants for the test pattern generator and device information block
`ifndef TPG_DEFS_VH
`define TPG_DEFS_VH
// register byte offsets
`define TPG_OFF_SEL 8'h00
`define TPG_OFF_STATUS 8'h04
`define TPG_OFF_VENDOR 8'h08
`define TPG_OFF_MODEL 8'h0C
`define TPG_OFF_MFR 8'h10
`define TPG_OFF_DEVVER 8'h14
`define TPG_OFF_FWVER 8'h18
`define TPG_OFF_SERIAL 8'h1C
`define TPG_OFF_SCAN 8'h20
`define TPG_OFF_SENS_W 8'h24
`define TPG_OFF_SENS_H 8'h28
`define TPG_OFF_MAX_W 8'h2C
`define TPG_OFF_MAX_H 8'h30
`define TPG_OFF_AOI_W 8'h34
`define TPG_OFF_AOI_H 8'h38
`define TPG_OFF_LABEL 8'h40
`define TPG_LABEL_WORDS 4
// selector codes
`define TPG_SEL_OFF 3'h0
`define TPG_SEL_FIX8 3'h1
`define TPG_SEL_MOV8 3'h2
`define TPG_SEL_MOV12 3'h3
`define TPG_SEL_FEAT8 3'h4
`define TPG_SEL_FEAT12 3'h5
`define TPG_SEL_COLOR 3'h6
`define TPG_SEL_RST 3'h0
// status fields
`define TPG_ST_BUSY 0
`define TPG_ST_CNT_LSB 16
// identification values, all arbitrary
`define TPG_ID_VENDOR 32'h56454E44
`define TPG_ID_MODEL 32'h4D4F4431
`define TPG_ID_MFR 32'h4E4F4E45
`define TPG_ID_DEVVER 32'h00010000
`define TPG_ID_FWVER 32'h00010002
`define TPG_ID_SERIAL 32'h12345678
`define TPG_ID_SCAN 32'h41524541
// geometry
`define TPG_SENS_W 12'h100
`define TPG_SENS_H 12'h0C0
`define TPG_MAX_W 12'h100
`define TPG_MAX_H 12'h0C0
// 1 on color variants, enables the color gradient
`define TPG_COLOR 1'b1
// pixel width and fifo depth
`define TPG_PIX_W 12
`define TPG_FIFO_D 8
`endif

// ===== tpg_fifo.v
// synchronous flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module tpg_fifo #(
   parameter W = 15,
   parameter D = 8
) (
   // clock and reset
   input wire core_clk_i,
   input wire nrst_i,
   // fill side
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [W-1:0] in_data_i,
   // drain side
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [W-1:0] out_data_o
);
   localparam AW = (D > 1) ? $clog2(D) : 1;
   reg [W-1:0] mem_q [0:D-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;
   integer i;

   assign in_ready_o = (cnt_q != D[AW:0]);
   assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
   assign out_data_o = mem_q[rp_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wp_q <= {AW{1'b0}};
         rp_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         for (i = 0; i < D; i = i + 1) begin
            mem_q[i] <= {W{1'b0}};
         end
      end else begin
         if (push) begin
            mem_q[wp_q] <= in_data_i;
            wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // tpg_fifo

// ===== tpg_top.v
// test pattern generator with selector and device information registers
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "tpg_defs.vh"
module tpg_top (
   // clock and reset
   input wire core_clk_i,
   input wire nrst_i,
   // register port
   input wire [7:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output wire [31:0] reg_rdata_o,
   // acquisition start pulse
   input wire acq_start_i,
   // sensor pixel stream
   input wire sens_valid_i,
   output wire sens_ready_o,
   input wire [11:0] sens_data_i,
   input wire sens_sof_i,
   input wire sens_eol_i,
   // pixel stream toward processing
   output wire pix_valid_o,
   input wire pix_ready_i,
   output wire [11:0] pix_data_o,
   output wire pix_sof_o,
   output wire pix_eol_o,
   output wire pix_bypass_o
);
   localparam FW = `TPG_PIX_W + 3;
   localparam ST_IDLE = 1'b0;
   localparam ST_RUN = 1'b1;

   reg [2:0] sel_q;
   reg [11:0] aoi_w_q;
   reg [11:0] aoi_h_q;
   reg [31:0] label_q [0:`TPG_LABEL_WORDS-1];
   reg [31:0] rdata_q;
   reg st_q;
   reg [2:0] mode_q;
   reg [11:0] cnt_q;
   reg [11:0] fcnt_q;
   reg [11:0] col_q;
   reg [11:0] row_q;
   reg [11:0] last_col_q;
   reg [11:0] last_row_q;
   reg [11:0] gen_pix;
   reg [31:0] rd_mux;
   wire [11:0] grad;
   wire [7:0] grad8;
   wire gen_sof;
   wire gen_eol;
   wire gen_last;
   wire pass;
   wire fifo_in_valid;
   wire fifo_in_ready;
   wire [FW-1:0] fifo_in;
   wire [FW-1:0] fifo_out;
   wire gen_push;
   wire sel_ok;
   integer k;

   // register port
   // pattern 6 is refused on mono variants; the selector keeps its old value
   assign sel_ok = (reg_wdata_i[2:0] <= `TPG_SEL_FEAT12) ||
                   ((reg_wdata_i[2:0] == `TPG_SEL_COLOR) && `TPG_COLOR);

   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sel_q <= `TPG_SEL_RST;
         aoi_w_q <= `TPG_MAX_W;
         aoi_h_q <= `TPG_MAX_H;
         for (k = 0; k < `TPG_LABEL_WORDS; k = k + 1) begin
            label_q[k] <= 32'h00000000;
         end
      end else if (reg_wr_i) begin
         if (reg_addr_i == `TPG_OFF_SEL && sel_ok) begin
            sel_q <= reg_wdata_i[2:0];
         end
         // zero or oversize area writes are ignored
         if (reg_addr_i == `TPG_OFF_AOI_W && reg_wdata_i[31:12] == 20'h00000 &&
             reg_wdata_i[11:0] != 12'h000 && reg_wdata_i[11:0] <= `TPG_MAX_W) begin
            aoi_w_q <= reg_wdata_i[11:0];
         end
         if (reg_addr_i == `TPG_OFF_AOI_H && reg_wdata_i[31:12] == 20'h00000 &&
             reg_wdata_i[11:0] != 12'h000 && reg_wdata_i[11:0] <= `TPG_MAX_H) begin
            aoi_h_q <= reg_wdata_i[11:0];
         end
         for (k = 0; k < `TPG_LABEL_WORDS; k = k + 1) begin
            if (reg_addr_i == `TPG_OFF_LABEL + k[5:0] * 8'h04) begin
               label_q[k] <= reg_wdata_i;
            end
         end
      end
   end

   always @* begin
      rd_mux = 32'h00000000;
      case (reg_addr_i)
         `TPG_OFF_SEL: rd_mux = {29'h00000000, sel_q};
         `TPG_OFF_STATUS: rd_mux = {4'h0, cnt_q, 15'h0000, st_q};
         `TPG_OFF_VENDOR: rd_mux = `TPG_ID_VENDOR;
         `TPG_OFF_MODEL: rd_mux = `TPG_ID_MODEL;
         `TPG_OFF_MFR: rd_mux = `TPG_ID_MFR;
         `TPG_OFF_DEVVER: rd_mux = `TPG_ID_DEVVER;
         `TPG_OFF_FWVER: rd_mux = `TPG_ID_FWVER;
         `TPG_OFF_SERIAL: rd_mux = `TPG_ID_SERIAL;
         `TPG_OFF_SCAN: rd_mux = `TPG_ID_SCAN;
         `TPG_OFF_SENS_W: rd_mux = {20'h00000, `TPG_SENS_W};
         `TPG_OFF_SENS_H: rd_mux = {20'h00000, `TPG_SENS_H};
         `TPG_OFF_MAX_W: rd_mux = {20'h00000, `TPG_MAX_W};
         `TPG_OFF_MAX_H: rd_mux = {20'h00000, `TPG_MAX_H};
         `TPG_OFF_AOI_W: rd_mux = {20'h00000, aoi_w_q};
         `TPG_OFF_AOI_H: rd_mux = {20'h00000, aoi_h_q};
         `TPG_OFF_LABEL: rd_mux = label_q[0];
         `TPG_OFF_LABEL + 8'h04: rd_mux = label_q[1];
         `TPG_OFF_LABEL + 8'h08: rd_mux = label_q[2];
         `TPG_OFF_LABEL + 8'h0C: rd_mux = label_q[3];
         default: rd_mux = 32'h00000000;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_q <= 32'h00000000;
      end else if (reg_rd_i) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= 32'h00000000;
      end
   end
   assign reg_rdata_o = rdata_q;

   // frame counter and sequencer
   assign gen_last = (col_q == last_col_q) && (row_q == last_row_q);
   assign gen_push = (st_q == ST_RUN) && fifo_in_ready;

   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q <= 12'h000;
         fcnt_q <= 12'h000;
         st_q <= ST_IDLE;
         mode_q <= `TPG_SEL_OFF;
         col_q <= 12'h000;
         row_q <= 12'h000;
         last_col_q <= 12'h000;
         last_row_q <= 12'h000;
      end else begin
         if (acq_start_i) begin
            // wraps naturally at 4096, a multiple of 256
            cnt_q <= cnt_q + 12'h001;
         end
         case (st_q)
            ST_IDLE: begin
               if (acq_start_i && sel_q != `TPG_SEL_OFF) begin
                  st_q <= ST_RUN;
                  mode_q <= sel_q;
                  fcnt_q <= cnt_q;
                  col_q <= 12'h000;
                  row_q <= 12'h000;
                  last_col_q <= aoi_w_q - 12'h001;
                  last_row_q <= aoi_h_q - 12'h001;
               end
            end
            ST_RUN: begin
               if (gen_push) begin
                  if (gen_last) begin
                     st_q <= ST_IDLE;
                  end else if (col_q == last_col_q) begin
                     col_q <= 12'h000;
                     row_q <= row_q + 12'h001;
                  end else begin
                     col_q <= col_q + 12'h001;
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // pattern arithmetic
   // adding the counter to the column moves the image leftward each frame
   assign grad = col_q + row_q + fcnt_q;
   assign grad8 = grad[7:0];

   always @* begin
      gen_pix = 12'h000;
      case (mode_q)
         `TPG_SEL_FIX8: gen_pix = {4'h0, col_q[7:0] + row_q[7:0]};
         `TPG_SEL_MOV8: gen_pix = {4'h0, grad8};
         `TPG_SEL_FEAT8: gen_pix = {4'h0, grad8};
         `TPG_SEL_MOV12: gen_pix = grad;
         `TPG_SEL_FEAT12: gen_pix = grad;
         // interleaved luma and chroma: even columns carry luma,
         // odd columns alternate a column-driven and row-driven chroma
         `TPG_SEL_COLOR: begin
            if (!col_q[0]) begin
               gen_pix = {4'h0, grad8};
            end else if (!col_q[1]) begin
               gen_pix = {4'h0, col_q[7:0] + fcnt_q[7:0]};
            end else begin
               gen_pix = {4'h0, row_q[7:0] - fcnt_q[7:0]};
            end
         end
         default: gen_pix = 12'h000;
      endcase
   end

   assign gen_sof = (col_q == 12'h000) && (row_q == 12'h000);
   assign gen_eol = (col_q == last_col_q);

   // source selection
   // sensor pixels flow only while no pattern is selected and none is running
   assign pass = (st_q == ST_IDLE) && (sel_q == `TPG_SEL_OFF);
   assign sens_ready_o = pass & fifo_in_ready;
   assign fifo_in_valid = pass ? sens_valid_i : (st_q == ST_RUN);
   // bypass flag travels with each pixel into the processing chain
   assign fifo_in = pass ? {1'b0, sens_sof_i, sens_eol_i, sens_data_i} :
                    {((mode_q != `TPG_SEL_FEAT8) && (mode_q != `TPG_SEL_FEAT12)),
                     gen_sof, gen_eol, gen_pix};

   tpg_fifo #(
      .W(FW),
      .D(`TPG_FIFO_D)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in),
      .out_valid_o(pix_valid_o),
      .out_ready_i(pix_ready_i),
      .out_data_o(fifo_out)
   );

   assign pix_bypass_o = fifo_out[FW-1];
   assign pix_sof_o = fifo_out[FW-2];
   assign pix_eol_o = fifo_out[FW-3];
   assign pix_data_o = fifo_out[11:0];
endmodule // tpg_top

// ===== tpg_chk.sv
// port assertions for the test pattern generator
`timescale 1ns/1ps
`include "tpg_defs.vh"
module tpg_chk (
   // clock and reset
   input wire core_clk_i,
   input wire nrst_i,
   // register port
   input wire [7:0] reg_addr_i,
   input wire reg_rd_i,
   input wire [31:0] reg_rdata_o,
   // streams
   input wire acq_start_i,
   input wire sens_valid_i,
   input wire sens_ready_o,
   input wire [11:0] sens_data_i,
   input wire sens_sof_i,
   input wire pix_valid_o,
   input wire pix_ready_i,
   input wire [11:0] pix_data_o,
   input wire pix_sof_o,
   input wire pix_bypass_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_frame_begin;
      $rose(pix_valid_o) && pix_bypass_o;
   endsequence
   property p_rd_idle;
      !reg_rd_i |=> reg_rdata_o == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
   property p_unmapped;
      reg_rd_i && reg_addr_i == 8'hFC |=> reg_rdata_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_vendor;
      reg_rd_i && reg_addr_i == `TPG_OFF_VENDOR |=> reg_rdata_o == `TPG_ID_VENDOR;
   endproperty
   a_vendor: assert property (p_vendor) else $error("vendor value wrong");
   property p_hold;
      pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_data_o) && $stable(pix_bypass_o);
   endproperty
   a_hold: assert property (p_hold) else $error("pixel changed while stalled");
   property p_pass;
      !pix_valid_o && sens_valid_i && sens_ready_o |=> pix_valid_o && !pix_bypass_o &&
         pix_data_o == $past(sens_data_i) && pix_sof_o == $past(sens_sof_i);
   endproperty
   a_pass: assert property (p_pass) else $error("sensor pixel not passed");
   property p_start;
      s_frame_begin |-> pix_sof_o && $past(acq_start_i, 2);
   endproperty
   a_start: assert property (p_start) else $error("frame start timing wrong");
   property p_stall;
      s_frame_begin |-> !sens_ready_o && !$past(sens_ready_o);
   endproperty
   a_stall: assert property (p_stall) else $error("sensor not stalled");
   property p_reset;
      $rose(nrst_i) |-> !pix_valid_o && reg_rdata_o == 32'h0;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs busy after reset");
endmodule // tpg_chk
bind tpg_top tpg_chk i_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .acq_start_i(acq_start_i),
   .sens_valid_i(sens_valid_i), .sens_ready_o(sens_ready_o), .sens_data_i(sens_data_i),
   .sens_sof_i(sens_sof_i), .pix_valid_o(pix_valid_o), .pix_ready_i(pix_ready_i),
   .pix_data_o(pix_data_o), .pix_sof_o(pix_sof_o), .pix_bypass_o(pix_bypass_o));

// ===== tpg_sink.sv
// downstream consumer model that can stall
`timescale 1ns/1ps
module tpg_sink (
   // clock and reset
   input wire core_clk_i,
   input wire nrst_i,
   // stall control and handshake
   input wire slow_i,
   output reg pix_ready_o
);
   reg [1:0] tick_q;
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tick_q <= 2'h0;
         pix_ready_o <= 1'b0;
      end else begin
         tick_q <= tick_q + 2'h1;
         // slow mode takes one pixel in four
         pix_ready_o <= !slow_i || tick_q == 2'h3;
      end
   end
endmodule // tpg_sink

// ===== tpg_top_bench.sv
// self-checking bench for the test pattern generator
`timescale 1ns/1ps
`include "tpg_defs.vh"
module tpg_top_bench;
   logic clk, nrst, wr, rd, acq, sv, ssof, seol, slow;
   logic [7:0] addr;
   logic [31:0] wd, q;
   logic [11:0] sd;
   wire [31:0] rdata;
   wire sready, pv, pr, psof, peol, pbyp;
   wire [11:0] pd;
   logic [15:0] v;
   logic [11:0] k;
   logic [2:0] mm;
   int fails = 0;
   int checks = 0;
   logic [39:0] rows [15] = '{{`TPG_OFF_VENDOR, `TPG_ID_VENDOR}, {`TPG_OFF_MODEL, `TPG_ID_MODEL},
      {`TPG_OFF_MFR, `TPG_ID_MFR}, {`TPG_OFF_DEVVER, `TPG_ID_DEVVER},
      {`TPG_OFF_FWVER, `TPG_ID_FWVER}, {`TPG_OFF_SERIAL, `TPG_ID_SERIAL},
      {`TPG_OFF_SCAN, `TPG_ID_SCAN}, {`TPG_OFF_SENS_W, 20'h0, `TPG_SENS_W},
      {`TPG_OFF_SENS_H, 20'h0, `TPG_SENS_H}, {`TPG_OFF_MAX_W, 20'h0, `TPG_MAX_W},
      {`TPG_OFF_MAX_H, 20'h0, `TPG_MAX_H}, {`TPG_OFF_AOI_W, 32'h100},
      {`TPG_OFF_AOI_H, 32'h0C0}, {`TPG_OFF_SEL, 32'h0}, {8'hFC, 32'h0}};
   tpg_top i_dut (.core_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wdata_i(wd),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .acq_start_i(acq),
      .sens_valid_i(sv), .sens_ready_o(sready), .sens_data_i(sd), .sens_sof_i(ssof),
      .sens_eol_i(seol), .pix_valid_o(pv), .pix_ready_i(pr), .pix_data_o(pd),
      .pix_sof_o(psof), .pix_eol_o(peol), .pix_bypass_o(pbyp));
   tpg_sink i_sink (.core_clk_i(clk), .nrst_i(nrst), .slow_i(slow), .pix_ready_o(pr));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task report_and_stop;
      if (fails == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wreg(input [7:0] a, input [31:0] d);
      @(posedge clk);
      wr <= 1'b1; addr <= a; wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rreg(input [7:0] a, output [31:0] d);
      @(posedge clk);
      rd <= 1'b1; addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   task automatic take(output [15:0] p);
      int n = 0;
      @(negedge clk);
      while (!(pv === 1'b1 && pr === 1'b1) && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n >= 200) begin
         fails++;
         report_and_stop;
      end
      p = {pbyp, psof, peol, pd};
   endtask
   function automatic [11:0] px(input [2:0] m, input [11:0] c, input [11:0] r, input [11:0] f);
      case (m)
         3'h1: px = (c + r) & 12'h0FF;
         3'h3, 3'h5: px = c + r + f;
         3'h6: px = c[0] ? (c[1] ? (r - f) & 12'h0FF : (c + f) & 12'h0FF) : (c + r + f) & 12'h0FF;
         default: px = (c + r + f) & 12'h0FF;
      endcase
   endfunction
   initial begin
      {nrst, wr, rd, acq, sv, ssof, seol, slow, addr, wd, sd} = '0;
      k = 12'h0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      chk({31'h0, pv}, 32'h0);
      wreg(`TPG_OFF_VENDOR, 32'h0);
      wreg(`TPG_OFF_SEL, 32'h7);
      wreg(`TPG_OFF_AOI_W, 32'h0);
      wreg(8'hFC, 32'hFFFFFFFF);
      for (int i = 0; i < 15; i++) begin
         rreg(rows[i][39:32], q);
         chk(q, rows[i][31:0]);
      end
      for (int i = 0; i < 4; i++) wreg(`TPG_OFF_LABEL + 4 * i, 32'hA55A0000 + i);
      for (int i = 0; i < 4; i++) begin
         rreg(`TPG_OFF_LABEL + 4 * i, q);
         chk(q, 32'hA55A0000 + i);
      end
      wreg(`TPG_OFF_AOI_W, 32'h4);
      wreg(`TPG_OFF_AOI_H, 32'h2);
      // sensor lines carry junk while patterns run
      for (int m = 1; m <= 7; m++) begin
         mm = (m == 7) ? 3'h1 : m[2:0];
         wreg(`TPG_OFF_SEL, {29'h0, mm});
         sv <= 1'b1; sd <= 12'hFFF; slow <= mm[0];
         @(posedge clk);
         acq <= 1'b1;
         @(posedge clk);
         @(posedge clk);
         acq <= 1'b0;
         for (int r = 0; r < 2; r++) for (int c = 0; c < 4; c++) begin
            take(v);
            chk(v, {mm != 3'h4 && mm != 3'h5, r == 0 && c == 0, c == 3,
               px(mm, c, r, k)});
         end
         chk({31'h0, sready}, 32'h0);
         k = k + 12'h2;
      end
      rreg(`TPG_OFF_STATUS, q);
      chk({q[27:16], q[0]}, {k, 1'b0});
      @(posedge clk);
      sv <= 1'b0;
      wreg(`TPG_OFF_SEL, 32'h0);
      sv <= 1'b1; sd <= 12'h5A3; ssof <= 1'b1;
      @(posedge clk);
      sv <= 1'b0;
      take(v);
      chk(v, 32'h25A3);
      chk({31'h0, sready}, 32'h1);
      // reset while a frame is under way
      wreg(`TPG_OFF_SEL, 32'h2);
      @(posedge clk);
      acq <= 1'b1;
      @(posedge clk);
      acq <= 1'b0;
      @(posedge clk);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      chk({30'h0, pv, sready}, 32'h1);
      rreg(`TPG_OFF_STATUS, q);
      chk(q, 32'h0);
      rreg(`TPG_OFF_SEL, q);
      chk(q, 32'h0);
      rreg(`TPG_OFF_LABEL, q);
      chk(q, 32'h0);
      report_and_stop;
   end
endmodule // tpg_top_bench
